// [ext_decode_pkg.sv]
// Constants and types for the extended instruction decoder
package ext_decode_pkg;
  localparam logic [7:0] OPC_PUSH_ALL = 8'hf4;
  localparam logic [7:0] OPC_POP_ALL = 8'hf5;
  localparam logic [7:0] OPC_LOW_POWER = 8'hf6;
  localparam logic [7:0] OPC_DEC_BRANCH = 8'he1;
  localparam logic [7:0] OPC_CMP32 = 8'hc5;
  localparam logic [7:0] OPC_BLOCK_COPY = 8'hc1;
  localparam logic [7:0] KEY_IDLE = 8'h01;
  localparam logic [7:0] KEY_POWERDOWN = 8'h02;
  localparam logic [7:0] ST_CTX_ONCHIP = 8'h0c;
  localparam logic [7:0] ST_CTX_OFFCHIP = 8'h12;
  localparam logic [7:0] ST_LP_LEGAL = 8'h08;
  localparam logic [7:0] ST_LP_ILLEGAL = 8'h19;
  localparam logic [7:0] ST_DJ_NOTTAKEN = 8'h06;
  localparam logic [7:0] ST_DJ_TAKEN = 8'h0a;
  localparam logic [7:0] ST_CMP32 = 8'h07;
  localparam logic [7:0] ST_BC_BASE = 8'h06;
  localparam logic [7:0] ST_BC_II = 8'h08;
  localparam logic [7:0] ST_BC_EI = 8'h0b;
  localparam logic [7:0] ST_BC_EE = 8'h0e;
  localparam logic [2:0] RST_OP_KIND = 3'h0;
  typedef enum logic [2:0] {
    OP_NONE, OP_PUSH_ALL, OP_POP_ALL, OP_LOW_POWER, OP_DEC_BRANCH, OP_CMP32, OP_BLOCK_COPY
  } op_kind_type;
  typedef enum logic [1:0] {BC_INT_INT, BC_EXT_INT, BC_EXT_EXT} copy_path_type;
endpackage

// [state_timer_if.sv]
// Carrier between the decoder and its state-count timer
`timescale 1ns/100ps
`default_nettype none
interface state_timer_if;
  logic load;
  logic [7:0] count;
  logic busy;
  logic done;
  modport ctrl (output load, output count, input busy, input done);
  modport timer (input load, input count, output busy, output done);
endinterface
`default_nettype wire

// [state_timer.sv]
// Down counter that spends a loaded number of states
`timescale 1ns/100ps
`default_nettype none
module state_timer (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  state_timer_if.timer tmr
);
  logic [7:0] cnt_r;
  logic done_r;
  wire logic last_w = (cnt_r == 8'h01);
  assign tmr.busy = (cnt_r != 8'h00);
  assign tmr.done = done_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= tmr.busy && last_w && !tmr.load;
      if (tmr.load) begin
        cnt_r <= tmr.count;
      end else if (tmr.busy) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [extended_instruction_decode.sv]
// Decoder and sequencer for six extended core instructions
// What this block does
// RULE1 - Opcode f4 pushes status, masks, window
// RULE2 - Opcode f5 pops them back, reverse order
// RULE3 - Push/pop: 12 states on-chip, 18 off
// RULE4 - Opcode f6 key 1 idle, 2 powerdown
// RULE5 - Low power: 8 states legal, 25 illegal
// RULE6 - Opcode e1 decrements word, branches nonzero
// RULE7 - Decrement branch: 6 not taken, 10 taken
// RULE8 - Opcode c5 compares 32-bit, src then dst
// RULE9 - Opcode c1 copies words via pointers
// RULE10 - Copy: 6 plus 8, 11, 14 per word
// RULE11 - Window select swaps readable and writable map
// RULE12 - Illegal key finishes without low power
`timescale 1ns/100ps
`default_nettype none
module extended_instruction_decode #(
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic fetch_valid_in,
  input wire logic [7:0] fetch_byte_in,
  input wire logic stack_offchip_in,
  input wire logic [15:0] word_reg_value_in,
  input wire logic [COUNT_W-1:0] copy_count_in,
  input wire logic [1:0] copy_path_in,
  input wire logic [7:0] window_select_reg_in,
  input wire logic sfr_write_only_in,
  input wire logic sfr_read_only_in,
  output logic fetch_ready_out,
  output logic instr_done_out,
  output logic push_all_context_out,
  output logic pop_all_context_out,
  output logic enter_idle_out,
  output logic enter_powerdown_out,
  output logic dec_write_out,
  output logic [15:0] dec_value_out,
  output logic branch_take_out,
  output logic [7:0] branch_disp_out,
  output logic compare_32bit_out,
  output logic block_copy_out,
  output logic [7:0] operand_a_out,
  output logic [7:0] operand_b_out,
  output logic unknown_opcode_out,
  output logic sfr_read_allow_out,
  output logic sfr_write_allow_out
);
  typedef enum logic [2:0] {S_OPC, S_BYTE1, S_BYTE2, S_RUN} dec_state_type;
  dec_state_type state_r, state_nxt;
  ext_decode_pkg::op_kind_type op_r;
  logic [7:0] b1_r, b2_r;
  logic started_r;
  state_timer_if tmr ();
  state_timer u_timer (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tmr(tmr));

  // The count comes from a word register, so a wider counter serves nothing
  if (COUNT_W < 1 || COUNT_W > 16) begin : g_count_w_check
    $error("COUNT_W must lie between 1 and 16");
  end

  function automatic ext_decode_pkg::op_kind_type decode_op(input logic [7:0] b);
    case (b)
      ext_decode_pkg::OPC_PUSH_ALL: decode_op = ext_decode_pkg::OP_PUSH_ALL; // RULE1
      ext_decode_pkg::OPC_POP_ALL: decode_op = ext_decode_pkg::OP_POP_ALL; // RULE2
      ext_decode_pkg::OPC_LOW_POWER: decode_op = ext_decode_pkg::OP_LOW_POWER; // RULE4
      ext_decode_pkg::OPC_DEC_BRANCH: decode_op = ext_decode_pkg::OP_DEC_BRANCH; // RULE6
      ext_decode_pkg::OPC_CMP32: decode_op = ext_decode_pkg::OP_CMP32; // RULE8
      ext_decode_pkg::OPC_BLOCK_COPY: decode_op = ext_decode_pkg::OP_BLOCK_COPY; // RULE9
      default: decode_op = ext_decode_pkg::OP_NONE;
    endcase
  endfunction

  // Byte count beyond the opcode
  function automatic logic [1:0] extra_bytes(input ext_decode_pkg::op_kind_type k);
    case (k)
      ext_decode_pkg::OP_LOW_POWER: extra_bytes = 2'd1;
      ext_decode_pkg::OP_DEC_BRANCH, ext_decode_pkg::OP_CMP32,
      ext_decode_pkg::OP_BLOCK_COPY: extra_bytes = 2'd2;
      default: extra_bytes = 2'd0;
    endcase
  endfunction

  wire ext_decode_pkg::op_kind_type new_op_w = decode_op(fetch_byte_in);
  wire logic take_w = fetch_valid_in && fetch_ready_out;
  wire logic key_idle_w = (b1_r == ext_decode_pkg::KEY_IDLE);
  wire logic key_pd_w = (b1_r == ext_decode_pkg::KEY_POWERDOWN);
  wire logic key_legal_w = key_idle_w || key_pd_w;
  wire logic [15:0] dec_w = word_reg_value_in - 16'h0001;
  wire logic dj_taken_w = (dec_w != 16'h0000);
  wire logic [7:0] per_xfer_w =
    (copy_path_in == ext_decode_pkg::BC_EXT_EXT) ? ext_decode_pkg::ST_BC_EE :
    (copy_path_in == ext_decode_pkg::BC_EXT_INT) ? ext_decode_pkg::ST_BC_EI :
    ext_decode_pkg::ST_BC_II; // RULE10
  // The done cycle of one transfer is already the first state of the next
  wire logic [7:0] xfer_load_w = per_xfer_w - 8'h01; // RULE10
  // Base states go to the timer first; each transfer then reloads it while xfer_left_r counts down
  logic [COUNT_W-1:0] xfer_left_r;
  logic [7:0] count_w;
  always_comb begin
    case (op_r)
      ext_decode_pkg::OP_PUSH_ALL, ext_decode_pkg::OP_POP_ALL:
        count_w = stack_offchip_in ? ext_decode_pkg::ST_CTX_OFFCHIP
                                   : ext_decode_pkg::ST_CTX_ONCHIP; // RULE3
      ext_decode_pkg::OP_LOW_POWER:
        count_w = key_legal_w ? ext_decode_pkg::ST_LP_LEGAL
                              : ext_decode_pkg::ST_LP_ILLEGAL; // RULE5
      ext_decode_pkg::OP_DEC_BRANCH:
        count_w = dj_taken_w ? ext_decode_pkg::ST_DJ_TAKEN
                             : ext_decode_pkg::ST_DJ_NOTTAKEN; // RULE7
      ext_decode_pkg::OP_CMP32: count_w = ext_decode_pkg::ST_CMP32; // RULE8
      ext_decode_pkg::OP_BLOCK_COPY: count_w = ext_decode_pkg::ST_BC_BASE; // RULE10
      default: count_w = 8'h01;
    endcase
  end

  wire logic run_entry_w = (state_r == S_RUN) && !started_r;
  wire logic copy_more_w = (op_r == ext_decode_pkg::OP_BLOCK_COPY) && (xfer_left_r != '0);
  wire logic finish_w = tmr.done && !copy_more_w;
  assign tmr.load = run_entry_w || (tmr.done && copy_more_w);
  assign tmr.count = run_entry_w ? count_w : xfer_load_w;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OPC: if (take_w) begin
        state_nxt = (extra_bytes(new_op_w) != 2'd0) ? S_BYTE1 : S_RUN;
      end
      S_BYTE1: if (take_w) begin
        state_nxt = (extra_bytes(op_r) == 2'd2) ? S_BYTE2 : S_RUN;
      end
      S_BYTE2: if (take_w) begin
        state_nxt = S_RUN;
      end
      S_RUN: if (finish_w) begin
        state_nxt = S_OPC;
      end
      default: state_nxt = S_OPC;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_OPC;
      op_r <= ext_decode_pkg::op_kind_type'(ext_decode_pkg::RST_OP_KIND);
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      started_r <= 1'b0;
      xfer_left_r <= '0;
    end else begin
      state_r <= state_nxt;
      // Marks that the timer already holds this instruction's count
      started_r <= (state_r == S_RUN) && !finish_w;
      if (take_w && state_r == S_OPC) begin
        op_r <= new_op_w;
      end
      if (take_w && state_r == S_BYTE1) begin
        b1_r <= fetch_byte_in;
      end
      if (take_w && state_r == S_BYTE2) begin
        b2_r <= fetch_byte_in;
      end
      if (run_entry_w) begin
        xfer_left_r <= copy_count_in; // RULE9
      end else if (tmr.done && copy_more_w) begin
        xfer_left_r <= xfer_left_r - COUNT_W'(1);
      end
    end
  end

  // Push, pop, decrement write and compare are issued as one-cycle pulses at the start of execution
  wire logic go_w = run_entry_w;
  // An illegal key matches neither decode, so it retires with no mode change
  wire logic lp_w = (op_r == ext_decode_pkg::OP_LOW_POWER); // RULE12
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fetch_ready_out <= 1'b0;
      instr_done_out <= 1'b0;
      push_all_context_out <= 1'b0;
      pop_all_context_out <= 1'b0;
      enter_idle_out <= 1'b0;
      enter_powerdown_out <= 1'b0;
      dec_write_out <= 1'b0;
      dec_value_out <= 16'h0000;
      branch_take_out <= 1'b0;
      branch_disp_out <= 8'h00;
      compare_32bit_out <= 1'b0;
      block_copy_out <= 1'b0;
      operand_a_out <= 8'h00;
      operand_b_out <= 8'h00;
      unknown_opcode_out <= 1'b0;
      sfr_read_allow_out <= 1'b0;
      sfr_write_allow_out <= 1'b0;
    end else begin
      fetch_ready_out <= (state_nxt != S_RUN);
      instr_done_out <= finish_w;
      push_all_context_out <= go_w && op_r == ext_decode_pkg::OP_PUSH_ALL; // RULE1
      pop_all_context_out <= go_w && op_r == ext_decode_pkg::OP_POP_ALL; // RULE2
      // Mode entry waits for the end, so it pulses in the same cycle as instr_done_out
      enter_idle_out <= finish_w && lp_w && key_idle_w; // RULE4
      enter_powerdown_out <= finish_w && lp_w && key_pd_w; // RULE4
      dec_write_out <= go_w && op_r == ext_decode_pkg::OP_DEC_BRANCH; // RULE6
      dec_value_out <= dec_w;
      branch_take_out <= finish_w && op_r == ext_decode_pkg::OP_DEC_BRANCH && dj_taken_w;
      branch_disp_out <= b2_r;
      compare_32bit_out <= go_w && op_r == ext_decode_pkg::OP_CMP32; // RULE8
      // The entry load starts the base states, not a transfer
      block_copy_out <= tmr.load && !run_entry_w; // RULE9
      operand_a_out <= b1_r;
      operand_b_out <= b2_r;
      unknown_opcode_out <= take_w && state_r == S_OPC
                            && new_op_w == ext_decode_pkg::OP_NONE;
      // Nonzero window swaps access of the special registers
      sfr_read_allow_out <= (window_select_reg_in != 8'h00) ? sfr_write_only_in
                                                            : !sfr_write_only_in; // RULE11
      sfr_write_allow_out <= (window_select_reg_in != 8'h00) ? sfr_read_only_in
                                                             : !sfr_read_only_in; // RULE11
    end
  end
endmodule
`default_nettype wire

// [ext_decode_chk_sva.sv]
// Port assertions for the extended instruction decoder
`timescale 1ns/100ps
`default_nettype none
module ext_decode_chk (
  input wire logic sys_clk_in, rst_n_in, fetch_valid_in, fetch_ready_out, instr_done_out,
  input wire logic [7:0] fetch_byte_in, window_select_reg_in,
  input wire logic push_all_context_out, pop_all_context_out, enter_idle_out,
  input wire logic enter_powerdown_out, branch_take_out, compare_32bit_out,
  input wire logic [15:0] dec_value_out,
  input wire logic sfr_write_only_in, sfr_read_allow_out,
  input wire logic sfr_read_only_in, sfr_write_allow_out, block_copy_out
);
  default clocking dcb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic take = fetch_valid_in && fetch_ready_out;
  // Operand bytes may hold any value, so only a byte taken between instructions is an opcode
  logic busy_r;
  wire logic opc_slot = !busy_r || instr_done_out;
  wire logic opc_take = take && opc_slot;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
    end else if (opc_take) begin
      busy_r <= 1'b1;
    end else if (instr_done_out) begin
      busy_r <= 1'b0;
    end
  end
  chk_push_after_take: assert property (
    opc_take && fetch_byte_in == ext_decode_pkg::OPC_PUSH_ALL |-> ##[1:3] push_all_context_out)
    else $error("no push");
  chk_pop_after_take: assert property (
    opc_take && fetch_byte_in == ext_decode_pkg::OPC_POP_ALL |-> ##[1:3] pop_all_context_out)
    else $error("no pop");
  chk_context_not_early: assert property (
    push_all_context_out || pop_all_context_out |=> !instr_done_out [*8]) else $error("early");
  chk_idle_at_end: assert property (
    enter_idle_out |-> instr_done_out && !enter_powerdown_out) else $error("idle");
  chk_powerdown_at_end: assert property (
    enter_powerdown_out |-> instr_done_out) else $error("powerdown");
  chk_branch_nonzero: assert property (
    branch_take_out |-> instr_done_out && dec_value_out != 16'h0000) else $error("branch");
  chk_compare_not_early: assert property (
    compare_32bit_out |=> !instr_done_out [*4]) else $error("compare early");
  chk_window_read: assert property (
    sfr_write_only_in |=> sfr_read_allow_out == ($past(window_select_reg_in) != 8'h00))
    else $error("window");
  chk_window_write: assert property (
    sfr_read_only_in |=> sfr_write_allow_out == ($past(window_select_reg_in) != 8'h00))
    else $error("window write");
  chk_copy_spacing: assert property (
    block_copy_out |=> !block_copy_out [*7]) else $error("copy spacing");
  cover property (push_all_context_out);
  cover property (enter_powerdown_out);
  cover property (branch_take_out);
  cover property (block_copy_out);
endmodule
bind extended_instruction_decode ext_decode_chk u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fetch_valid_in(fetch_valid_in),
  .fetch_ready_out(fetch_ready_out), .instr_done_out(instr_done_out),
  .fetch_byte_in(fetch_byte_in), .window_select_reg_in(window_select_reg_in),
  .push_all_context_out(push_all_context_out), .pop_all_context_out(pop_all_context_out),
  .enter_idle_out(enter_idle_out), .enter_powerdown_out(enter_powerdown_out),
  .branch_take_out(branch_take_out), .compare_32bit_out(compare_32bit_out),
  .dec_value_out(dec_value_out), .sfr_write_only_in(sfr_write_only_in),
  .sfr_read_allow_out(sfr_read_allow_out), .sfr_read_only_in(sfr_read_only_in),
  .sfr_write_allow_out(sfr_write_allow_out), .block_copy_out(block_copy_out));
`default_nettype wire

// [far_side_model.sv]
// Word register beside the decoder, written back by decrement instructions
`timescale 1ns/100ps
`default_nettype none
module far_side_model #(parameter logic [15:0] START = 16'h0002) (
  input wire logic sys_clk_in, rst_n_in, dec_write_in, done_in,
  input wire logic [15:0] dec_value_in,
  output logic [15:0] word_reg_out
);
  logic pend_r;
  // Written back only at instruction end, so the source stays steady while decoding
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) word_reg_out <= START;
    else if (pend_r && done_in) word_reg_out <= dec_value_in;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) pend_r <= 1'b0;
    else pend_r <= dec_write_in || (pend_r && !done_in);
endmodule
`default_nettype wire

// [extended_instruction_decode_bench.sv]
// Self-checking bench for the extended instruction decoder
`timescale 1ns/100ps
`default_nettype none
module extended_instruction_decode_bench;
  logic sys_clk_in = 0, rst_n_in = 0, fetch_valid_in = 0, stack_offchip_in = 0;
  logic sfr_write_only_in = 1, sfr_read_only_in = 0;
  logic [7:0] fetch_byte_in = 8'h00, window_select_reg_in = 8'h01;
  logic [15:0] copy_count_in = 16'h0003;
  logic [1:0] copy_path_in = 2'h0;
  wire logic [15:0] word_reg_value_in, dec_value_out;
  wire logic [7:0] branch_disp_out, operand_a_out, operand_b_out;
  wire logic fetch_ready_out, instr_done_out, push_all_context_out, pop_all_context_out;
  wire logic enter_idle_out, enter_powerdown_out, dec_write_out, branch_take_out;
  wire logic compare_32bit_out, block_copy_out, unknown_opcode_out;
  wire logic sfr_read_allow_out, sfr_write_allow_out;
  wire logic [7:0] pv = {unknown_opcode_out, push_all_context_out, pop_all_context_out,
    enter_idle_out,
    enter_powerdown_out, branch_take_out, compare_32bit_out, block_copy_out};
  int miscompares = 0, checked = 0, cyc = 0, base = -1;
  int n [8] = '{default: 0};
  int d [8];
  extended_instruction_decode u_dut (.*);
  far_side_model u_far (.sys_clk_in, .rst_n_in, .dec_write_in(dec_write_out),
    .done_in(instr_done_out), .dec_value_in(dec_value_out), .word_reg_out(word_reg_value_in));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++) n[i] <= n[i] + int'(pv[i] === 1'b1);
    if (cyc == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Latency runs from the last byte taken; the first run fixes the entry overhead
  task automatic op(input logic [7:0] opc, input logic [15:0] ops, input int nb, st);
    int s [8];
    int lat;
    s = n;
    for (int i = 0; i < nb; i++) begin
      fetch_byte_in = i == 0 ? opc : i == 1 ? ops[15:8] : ops[7:0];
      fetch_valid_in = 1'b1;
      while (fetch_ready_out !== 1'b1) @(posedge sys_clk_in) #1;
      @(posedge sys_clk_in) #1;
    end
    fetch_valid_in = 1'b0;
    for (lat = 1; instr_done_out !== 1'b1 && lat < 300; lat++) @(posedge sys_clk_in) #1;
    @(posedge sys_clk_in) #1;
    foreach (d[i]) d[i] = n[i] - s[i];
    if (base < 0) base = lat - st;
    chk("states", 16'(base + st), 16'(lat));
  endtask
  task automatic t_context;
    for (int i = 0; i < 4; i++) begin
      stack_offchip_in = i[1];
      op(i[0] ? 8'hf5 : 8'hf4, 16'h0000, 1, i[1] ? 18 : 12);
      chk("push pop", {8'(!i[0]), 8'(i[0])}, {8'(d[6]), 8'(d[5])});
    end
    chk("overhead", 16'h0001, 16'(base >= 0 && base <= 4));
    // An unknown opcode retires as a one-state no-op
    op(8'h00, 16'h0000, 1, 1);
    chk("unknown opcode", 16'h0001, 16'(d[7]));
    $display("context test done");
  endtask
  task automatic t_window;
    for (int w = 0; w < 8; w++) begin
      window_select_reg_in = w[2] ? 8'h04 : 8'h00;
      sfr_write_only_in = w[0];
      sfr_read_only_in = w[1];
      @(posedge sys_clk_in) #1;
      chk("read allow", 16'(w[2] ? w[0] : !w[0]), 16'(sfr_read_allow_out));
      chk("write allow", 16'(w[2] ? w[1] : !w[1]), 16'(sfr_write_allow_out));
    end
    $display("window test done");
  endtask
  task automatic t_low_power;
    for (int k = 0; k < 4; k++) begin
      op(8'hf6, {8'(k), 8'h00}, 2, k == 1 || k == 2 ? 8 : 25);
      chk("idle powerdown", {8'(k == 1), 8'(k == 2)}, {8'(d[4]), 8'(d[3])});
    end
    $display("low power test done");
  endtask
  task automatic t_dec_branch;
    for (int i = 0; i < 2; i++) begin
      op(8'he1, 16'h1afc, 3, i == 0 ? 10 : 6);
      chk("taken count", {8'(i == 0), 8'(1 - i)}, {8'(d[2]), dec_value_out[7:0]});
      chk("displacement", 16'h00fc, {8'h00, branch_disp_out});
    end
    $display("decrement test done");
  endtask
  task automatic t_long_ops;
    for (int p = 0; p < 4; p++) begin
      copy_path_in = 2'(p % 3);
      op(p == 3 ? 8'hc5 : 8'hc1, 16'h3034, 3, p == 3 ? 7 : 6 + 3 * (8 + 3 * p));
      chk("copy compare", {8'(p == 3 ? 0 : 3), 8'(p == 3)}, {8'(d[0]), 8'(d[1])});
      chk("operands", 16'h3034, {operand_a_out, operand_b_out});
    end
    $display("long op test done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (2) @(posedge sys_clk_in) #1;
    t_context;
    t_low_power;
    t_dec_branch;
    t_long_ops;
    t_window;
    complete_run;
  end
endmodule
`default_nettype wire
